//--- hdl/a2q_map.svh
// a2q_map.svh: addresses, field positions, reset values of the config store
// assumes 12-bit configuration words at 4-bit word addresses
`ifndef A2Q_MAP_SVH
`define A2Q_MAP_SVH

// ==========================================================================
// word addresses
`define A2Q_ADDR_ZP      4'h6
`define A2Q_ADDR_QCFG    4'h7
`define A2Q_ADDR_LOCK    4'h8
`define A2Q_ADDR_DIAG    4'h9
`define A2Q_ADDR_COMM    4'ha

// ==========================================================================
// quadrature word fields
`define A2Q_QCFG_RD      9
`define A2Q_QCFG_ZMODE   8
`define A2Q_QCFG_EN      7
`define A2Q_QCFG_HYS     6:4
`define A2Q_QCFG_RES     3:0

// commutation word fields
`define A2Q_COMM_EN      6
`define A2Q_COMM_HYS     5:3
`define A2Q_COMM_RES     2:0

// lock and diagnosis fields
`define A2Q_LOCK_FLD     1:0
`define A2Q_LOCK_OPEN    2'h3
`define A2Q_DIAG_FLUX    1
`define A2Q_DIAG_TRACK   0

// ==========================================================================
// reset values
`define A2Q_RST_ZP       12'h000
`define A2Q_RST_QCFG     12'h0a0
`define A2Q_RST_LOCK     12'h003
`define A2Q_RST_DIAG     12'h000
`define A2Q_RST_COMM     12'h052

// writable bits of each word
`define A2Q_MSK_ZP       12'hfff
`define A2Q_MSK_QCFG     12'h3ff
`define A2Q_MSK_LOCK     12'h003
`define A2Q_MSK_DIAG     12'h003
`define A2Q_MSK_COMM     12'h07f

`endif

//--- hdl/a2q_pkg.sv
// a2q_pkg: shared types of the angle to quadrature/commutation block
// assumes the constants come from a2q_map.svh
package a2q_pkg;

	// ==================================================================
	// types
	typedef logic [11:0] a2q_angle_t;   // one revolution in 4096 steps
	typedef logic [11:0] a2q_word_t;    // one configuration word
	typedef logic [3:0]  a2q_addr_t;    // configuration word address
	typedef logic [2:0]  a2q_thr_t;     // hysteresis step threshold

endpackage

//--- hdl/a2q_hyst.sv
// a2q_hyst: angle hysteresis filter, one per output path
// assumes one clock, synchronous reset, angle sampled every cycle
`timescale 1ns/1ps

module a2q_hyst
	import a2q_pkg::*;
(
	// clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       rst_i,
	// control
	input  wire logic       run_i,    // decoding allowed
	input  wire a2q_thr_t   thr_i,    // 0 follows, else min step
	// angle
	input  wire a2q_angle_t ang_i,
	output a2q_angle_t      held_o
);

	// ==================================================================
	// distance from held value, modulo one turn
	a2q_angle_t diff;   // signed step since last update
	a2q_angle_t mag;    // its size
	assign diff = ang_i - held_o;
	assign mag  = diff[11] ? a2q_angle_t'(-diff) : diff;

	// ==================================================================
	// held angle: moves only after a big enough step, so with a threshold
	// of 2 or more one-LSB dither of the tracking loop never reaches the outputs
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			held_o <= 12'h000;
		else if (run_i && (thr_i == 3'h0 || mag >= 12'(thr_i)))
			held_o <= ang_i;
	end

endmodule

//--- hdl/a2q_top.sv
// a2q_top: absolute angle to quadrature and commutation outputs
// assumes the angle is synchronous to sys_clk_i; config words arrive
// over a plain word write port fed by the serial framing outside
`timescale 1ns/1ps
`include "a2q_map.svh"

module a2q_top
	import a2q_pkg::*;
(
	// clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       rst_i,
	// angle source
	input  wire a2q_angle_t absolute_angle_i,
	// configuration word port
	input  wire logic       cfg_we_i,
	input  wire a2q_addr_t  cfg_addr_i,
	input  wire a2q_word_t  cfg_wdata_i,
	output a2q_word_t       cfg_rdata_o,
	// quadrature pins
	output logic            quad_a_o,
	output logic            quad_b_o,
	output logic            quad_z_o,
	output logic            quad_oe_o,
	// commutation pins
	output logic            comm_u_o,
	output logic            comm_v_o,
	output logic            comm_w_o,
	output logic            comm_oe_o,
	// diagnosis enables for the fault detectors, and lock status
	output logic            flux_check_en_o,
	output logic            track_check_en_o,
	output logic            config_locked_o
);

	// ==================================================================
	// decoders
	// hysteresis code to filter threshold; 0 means follow directly
	function automatic a2q_thr_t hys_thr(input logic [2:0] code);
		if (code == 3'h0)
			hys_thr = 3'h0;       // invalid: no filtering
		else if (code == 3'h1)
			hys_thr = 3'h2;       // 0 LSB: two steps same way
		else if (code == 3'h3)
			hys_thr = 3'h4;       // 2 LSB
		else if (code == 3'h4)
			hys_thr = 3'h5;       // 3 LSB
		else
			hys_thr = 3'h3;       // 1 LSB, all other codes
	endfunction

	// quadrature resolution code to pulses per turn
	function automatic logic [10:0] quad_ppr(input logic [3:0] code);
		case (code)
			4'h0: quad_ppr = 11'h400;   // 1024
			4'h1: quad_ppr = 11'h200;   // 512
			4'h2: quad_ppr = 11'h100;   // 256
			4'h3: quad_ppr = 11'h080;   // 128
			4'h4: quad_ppr = 11'h3e8;   // 1000
			4'h5: quad_ppr = 11'h384;   // 900
			4'h6: quad_ppr = 11'h320;   // 800
			4'h7: quad_ppr = 11'h2bc;   // 700
			4'h8: quad_ppr = 11'h258;   // 600
			4'h9: quad_ppr = 11'h1f4;   // 500
			4'ha: quad_ppr = 11'h190;   // 400
			4'hb: quad_ppr = 11'h168;   // 360
			4'hc: quad_ppr = 11'h12c;   // 300
			4'hd: quad_ppr = 11'h0c8;   // 200
			4'he: quad_ppr = 11'h064;   // 100
			default: quad_ppr = 11'h032; // 50
		endcase
	endfunction

	// ==================================================================
	// configuration store
	a2q_word_t zero_point_offset_r;   // zero angle
	a2q_word_t quad_cfg_r;            // direction, index form, quad
	a2q_word_t config_lock_field_r;   // lock word
	a2q_word_t diag_disable_bits_r;   // diagnosis disables
	a2q_word_t commutation_cfg_r;     // commutation settings
	logic      locked;                // lock engaged
	logic      wr_ok;                 // a write that may land

	assign locked = config_lock_field_r[`A2Q_LOCK_FLD] != `A2Q_LOCK_OPEN;
	assign wr_ok  = cfg_we_i && !locked;

	// word writes; the lock word is guarded like the rest, so once
	// engaged no write can reopen it
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			zero_point_offset_r <= `A2Q_RST_ZP;
			quad_cfg_r          <= `A2Q_RST_QCFG;
			config_lock_field_r <= `A2Q_RST_LOCK;
			diag_disable_bits_r <= `A2Q_RST_DIAG;
			commutation_cfg_r   <= `A2Q_RST_COMM;
		end
		else if (wr_ok)
		begin
			if (cfg_addr_i == `A2Q_ADDR_ZP)
				zero_point_offset_r <= cfg_wdata_i & `A2Q_MSK_ZP;
			else if (cfg_addr_i == `A2Q_ADDR_QCFG)
				quad_cfg_r <= cfg_wdata_i & `A2Q_MSK_QCFG;
			else if (cfg_addr_i == `A2Q_ADDR_LOCK)
				config_lock_field_r <= cfg_wdata_i & `A2Q_MSK_LOCK;
			else if (cfg_addr_i == `A2Q_ADDR_DIAG)
				diag_disable_bits_r <= cfg_wdata_i & `A2Q_MSK_DIAG;
			else if (cfg_addr_i == `A2Q_ADDR_COMM)
				commutation_cfg_r <= cfg_wdata_i & `A2Q_MSK_COMM;
		end
	end

	// read back; unmapped words read zero
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			cfg_rdata_o <= 12'h000;
		else if (cfg_addr_i == `A2Q_ADDR_ZP)
			cfg_rdata_o <= zero_point_offset_r;
		else if (cfg_addr_i == `A2Q_ADDR_QCFG)
			cfg_rdata_o <= quad_cfg_r;
		else if (cfg_addr_i == `A2Q_ADDR_LOCK)
			cfg_rdata_o <= config_lock_field_r;
		else if (cfg_addr_i == `A2Q_ADDR_DIAG)
			cfg_rdata_o <= diag_disable_bits_r;
		else if (cfg_addr_i == `A2Q_ADDR_COMM)
			cfg_rdata_o <= commutation_cfg_r;
		else
			cfg_rdata_o <= 12'h000;
	end

	// diagnosis enables and lock status, registered
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			flux_check_en_o  <= 1'b0;
			track_check_en_o <= 1'b0;
			config_locked_o  <= 1'b0;
		end
		else
		begin
			flux_check_en_o  <= !diag_disable_bits_r[`A2Q_DIAG_FLUX];
			track_check_en_o <= !diag_disable_bits_r[`A2Q_DIAG_TRACK];
			config_locked_o  <= locked;
		end
	end

	// ==================================================================
	// start-up: decoding waits one cycle after reset so the filters first
	// take a registered rel_ang_r, not its reset value
	logic run_r;   // decoding running
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			run_r <= 1'b0;
		else
			run_r <= 1'b1;
	end

	// ==================================================================
	// angle relative to zero point, in the chosen direction
	a2q_angle_t rel_ang_r;   // zero-referenced angle
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			rel_ang_r <= 12'h000;
		else if (quad_cfg_r[`A2Q_QCFG_RD])
			rel_ang_r <= zero_point_offset_r - absolute_angle_i;
		else
			rel_ang_r <= absolute_angle_i - zero_point_offset_r;
	end

	// one filter per path; with unequal settings the two held angles
	// differ, which shifts commutation against quadrature
	a2q_angle_t quad_held;   // filtered angle, quadrature path
	a2q_angle_t comm_held;   // filtered angle, commutation path

	a2q_hyst u_quad_hyst (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.run_i     (run_r),
		.thr_i     (hys_thr(quad_cfg_r[`A2Q_QCFG_HYS])),
		.ang_i     (rel_ang_r),
		.held_o    (quad_held)
	);

	a2q_hyst u_comm_hyst (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.run_i     (run_r),
		.thr_i     (hys_thr(commutation_cfg_r[`A2Q_COMM_HYS])),
		.ang_i     (rel_ang_r),
		.held_o    (comm_held)
	);

	// ==================================================================
	// scaling; the shifts drop the fraction, truncating toward zero
	logic [22:0] qprod;        // angle times quadrature pulses
	a2q_angle_t  scaled_quadrature_angle;
	logic [3:0]  comm_pulses;  // commutation pulses per turn
	logic [17:0] cprod;        // angle times six times pulses
	logic [5:0]  scaled_commutation_angle;
	logic [2:0]  sixth;        // position within one electrical cycle

	assign qprod = 23'(quad_held) *
		23'(quad_ppr(quad_cfg_r[`A2Q_QCFG_RES]));
	assign scaled_quadrature_angle = qprod[21:10];
	assign comm_pulses = {1'b0, commutation_cfg_r[`A2Q_COMM_RES]} + 4'h1;
	assign cprod = 18'(comm_held) * 18'(comm_pulses) * 18'h6;
	assign scaled_commutation_angle = cprod[17:12];
	// modulo six folds every pulse N onto the same pattern
	assign sixth = 3'(scaled_commutation_angle % 6'h6);

	// ==================================================================
	// quadrature outputs, registered so they never glitch
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			quad_a_o  <= 1'b0;
			quad_b_o  <= 1'b0;
			quad_z_o  <= 1'b0;
			quad_oe_o <= 1'b0;
		end
		else if (run_r)
		begin
			quad_a_o  <= scaled_quadrature_angle[1];
			quad_b_o  <= scaled_quadrature_angle[1] ^
				scaled_quadrature_angle[0];
			if (quad_cfg_r[`A2Q_QCFG_ZMODE])
				quad_z_o <= !quad_held[11];
			else
				quad_z_o <= ~|scaled_quadrature_angle;
			quad_oe_o <= quad_cfg_r[`A2Q_QCFG_EN];
		end
	end

	// commutation outputs; sixths 0-1 U, 2-3 V, W low in 1-2
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			comm_u_o  <= 1'b0;
			comm_v_o  <= 1'b0;
			comm_w_o  <= 1'b0;
			comm_oe_o <= 1'b0;
		end
		else if (run_r)
		begin
			comm_u_o  <= sixth < 3'h2;
			comm_v_o  <= sixth >= 3'h2 && sixth < 3'h4;
			comm_w_o  <= !(sixth >= 3'h1 && sixth < 3'h3);
			comm_oe_o <= commutation_cfg_r[`A2Q_COMM_EN];
		end
	end
	// zero point reaches both paths through rel_ang_r
	// U and V each span a third of the electrical cycle, W two thirds

	// ==================================================================
	// checks
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	sequence s_lock_write;
		cfg_we_i && !locked && cfg_addr_i == `A2Q_ADDR_LOCK &&
			cfg_wdata_i[1:0] != `A2Q_LOCK_OPEN;
	endsequence

	sequence s_comm_off_write;
		cfg_we_i && !locked && cfg_addr_i == `A2Q_ADDR_COMM &&
			!cfg_wdata_i[`A2Q_COMM_EN];
	endsequence

	chk_lock_engage: assert property (s_lock_write |=> ##1 config_locked_o)
		else $error("lock did not engage");
	chk_lock_sticky: assert property (locked |=> locked)
		else $error("lock released");
	chk_locked_ignore: assert property (locked && cfg_we_i |=>
		$stable(zero_point_offset_r) && $stable(quad_cfg_r) &&
		$stable(commutation_cfg_r))
		else $error("write landed while locked");
	chk_diag_flux: assert property (cfg_we_i && !locked &&
		cfg_addr_i == `A2Q_ADDR_DIAG && cfg_wdata_i[1:0] == 2'h2 |=>
		##1 !flux_check_en_o && track_check_en_o)
		else $error("diagnosis disables wrong");
	chk_comm_float: assert property ((s_comm_off_write and run_r) |=>
		##1 !comm_oe_o)
		else $error("commutation pins still driven");
	chk_quad_phase: assert property (run_r |=>
		quad_a_o == $past(scaled_quadrature_angle[1]) &&
		quad_b_o == $past(^scaled_quadrature_angle[1:0]))
		else $error("quadrature phases wrong");
	chk_index_zero: assert property (run_r &&
		!quad_cfg_r[`A2Q_QCFG_ZMODE] &&
		scaled_quadrature_angle == 12'h000 |=> quad_z_o)
		else $error("index missing at zero");
	chk_uvw_pattern: assert property (run_r && sixth == 3'h2 |=>
		!comm_u_o && comm_v_o && !comm_w_o)
		else $error("commutation pattern wrong");
	chk_u_window: assert property (run_r |=>
		comm_u_o == ($past(sixth) < 3'h2))
		else $error("u phase wrong");

endmodule

//--- test/a2q_drive_model.sv
// a2q_drive_model: far-side receiver of the quadrature and phase pins
// assumes oe high while the block drives; lines carry pull-ups
`timescale 1ns/1ps

module a2q_drive_model
(
	// quadrature pins
	input  wire logic       a_i,
	input  wire logic       b_i,
	input  wire logic       z_i,
	input  wire logic       qoe_i,
	// commutation pins
	input  wire logic       u_i,
	input  wire logic       v_i,
	input  wire logic       w_i,
	input  wire logic       coe_i,
	// levels seen by the receiver
	output logic [5:0]      pins_o
);
	// ==================================================================
	// released pins float up, so a stuck driver shows as a wrong level
	assign pins_o = {coe_i ? {w_i, v_i, u_i} : 3'b111,
		qoe_i ? {z_i, b_i, a_i} : 3'b111};
endmodule

//--- test/test_angle_to_quadrature_commutation.sv
// test_angle_to_quadrature_commutation: self-checking bench of a2q_top
// assumes a2q_drive_model resolves the pins with pull-ups
`timescale 1ns/1ps
`include "a2q_map.svh"

module test_angle_to_quadrature_commutation
	import a2q_pkg::*;
	;
	// ==================================================================
	// stimulus and pins
	logic       sys_clk_i = 1'b0;
	logic       rst_i = 1'b1;
	a2q_angle_t absolute_angle = 12'h000;
	logic       we = 1'b0;
	a2q_addr_t  addr = 4'h0;
	a2q_word_t  wdata = 12'h000;
	a2q_word_t  rdata;
	logic       qa, qb, qz, qoe, cu, cv, cw, coe, flux, track, lock;
	logic [5:0] pins;
	// expected results wait here until the monitor sees them
	typedef struct { string nm; int sel; logic [11:0] e; } a2q_note_t;
	a2q_note_t  notes[$];
	a2q_note_t  cur;
	logic [11:0] seen;
	event       obs;
	int         errors = 0;
	int         comparisons = 0;
	// mirror of the configuration the bench has written
	int         zp = 0, qc = 0, cc = 2, zm = 0, qen = 1, cen = 1, dr = 0;
	int         qppr[16] = '{1024, 512, 256, 128, 1000, 900, 800, 700,
		600, 500, 400, 360, 300, 200, 100, 50};

	initial
		forever #2.5 sys_clk_i = ~sys_clk_i;

	a2q_top dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.absolute_angle_i(absolute_angle), .cfg_we_i(we), .cfg_addr_i(addr),
		.cfg_wdata_i(wdata), .cfg_rdata_o(rdata), .quad_a_o(qa),
		.quad_b_o(qb), .quad_z_o(qz), .quad_oe_o(qoe), .comm_u_o(cu),
		.comm_v_o(cv), .comm_w_o(cw), .comm_oe_o(coe),
		.flux_check_en_o(flux), .track_check_en_o(track),
		.config_locked_o(lock));

	a2q_drive_model model (.a_i(qa), .b_i(qb), .z_i(qz), .qoe_i(qoe),
		.u_i(cu), .v_i(cv), .w_i(cw), .coe_i(coe), .pins_o(pins));

	// ==================================================================
	// expected pins {w,v,u,z,b,a} for an angle, from the mirror
	function automatic logic [5:0] exp_pins(int a);
		int r, q, c, s;
		logic [5:0] p;
		r = (dr ? zp - a : a - zp) & 4095;
		q = (r * 4 * qppr[qc] / 4096) & 4095;
		c = r * 6 * (cc + 1) / 4096;
		s = c % 6;
		p = {!(s == 1 || s == 2), s == 2 || s == 3, s < 2,
			zm ? r < 2048 : q == 0, q[1] ^ q[0], q[1]};
		if (qen == 0)
			p[2:0] = 3'b111;
		if (cen == 0)
			p[5:3] = 3'b111;
		return p;
	endfunction

	task automatic note(string n, int sel, logic [11:0] e);
		notes.push_back('{n, sel, e});
		-> obs;
	endtask

	task automatic check(string n, logic [11:0] s, logic [11:0] e);
		comparisons++;
		if (s !== e)
		begin
			errors++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask

	// one-cycle write strobe, taken at the rising edge in between
	task automatic wr(a2q_addr_t a, a2q_word_t d);
		@(negedge sys_clk_i);
		we = 1'b1;
		addr = a;
		wdata = d;
		@(negedge sys_clk_i);
		we = 1'b0;
	endtask

	task automatic rd(a2q_addr_t a, a2q_word_t e);
		@(negedge sys_clk_i);
		addr = a;
		@(negedge sys_clk_i);
		note("rdata", 0, e);
	endtask

	// quadrature part may lag behind when its filter holds
	task automatic pin(int a, int h);
		logic [5:0] pc, pq;
		pc = exp_pins(a);
		pq = exp_pins(h);
		@(negedge sys_clk_i);
		absolute_angle = a[11:0];
		repeat (4) @(negedge sys_clk_i);
		note("pins", 1, {6'h00, pc[5:3], pq[2:0]});
	endtask

	task automatic set_q(int z, int e, int h, int r);
		zm = z;
		qen = e;
		qc = r;
		wr(`A2Q_ADDR_QCFG, 12'(z * 256 + e * 128 + h * 16 + r));
	endtask

	task automatic set_c(int e, int h, int r);
		cen = e;
		cc = r;
		wr(`A2Q_ADDR_COMM, 12'(e * 64 + h * 8 + r));
	endtask

	task automatic test_done();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ==================================================================
	// monitor: pairs each settled result with the oldest note
	always @(obs)
		while (notes.size() > 0)
		begin
			cur = notes.pop_front();
			case (cur.sel)
				0: seen = rdata;
				1: seen = {6'h00, pins};
				default: seen = {9'h000, lock, flux, track};
			endcase
			check(cur.nm, seen, cur.e);
		end

	// watchdog: the whole run needs far less than this
	initial
	begin
		#200000;
		errors++;
		test_done();
	end

	// ==================================================================
	// main sequence
	initial
	begin
		int a;
		void'($urandom(32'h9d2133ed));
		repeat (16) @(negedge sys_clk_i);
		rst_i = 1'b0;
		rd(`A2Q_ADDR_ZP, `A2Q_RST_ZP);
		rd(`A2Q_ADDR_QCFG, `A2Q_RST_QCFG);
		rd(`A2Q_ADDR_LOCK, `A2Q_RST_LOCK);
		rd(`A2Q_ADDR_DIAG, `A2Q_RST_DIAG);
		rd(`A2Q_ADDR_COMM, `A2Q_RST_COMM);
		rd(4'h3, 12'h000);
		note("flags", 2, 12'h003);
		pin(0, 0);
		$display("reset test done");
		// every resolution code, random angles plus the last step
		for (int i = 0; i < 16; i++)
		begin
			set_q(0, 1, 0, i);
			set_c(1, 0, i % 8);
			pin(4095, 4095);
			repeat (3)
			begin
				a = $urandom % 4096;
				pin(a, a);
			end
		end
		$display("resolution test done");
		set_q(0, 0, 0, 0);
		set_c(0, 0, 2);
		pin(1234, 1234);
		$display("enable test done");
		zp = $urandom % 4096;
		wr(`A2Q_ADDR_ZP, zp[11:0]);
		set_c(1, 0, 2);
		set_q(1, 1, 0, 0);
		pin(zp + 2047, zp + 2047);
		pin(zp + 2048, zp + 2048);
		set_q(0, 1, 0, 0);
		pin(zp, zp);
		pin(zp + 1, zp + 1);
		// reversed direction: angle counts down from the zero point
		dr = 1;
		wr(`A2Q_ADDR_QCFG, 12'h280);
		pin(zp + 5, zp + 5);
		dr = 0;
		set_q(0, 1, 0, 0);
		$display("zero point test done");
		zp = 0;
		wr(`A2Q_ADDR_ZP, 12'h000);
		// settle both filters on zero before any threshold applies
		pin(0, 0);
		set_q(0, 1, 1, 0);
		pin(0, 0);
		pin(1, 0);
		pin(3, 3);
		// 3 LSB then 2 LSB thresholds on the quadrature path
		set_q(0, 1, 4, 0);
		pin(7, 3);
		pin(8, 8);
		set_q(0, 1, 3, 0);
		pin(11, 8);
		pin(12, 12);
		// 2 LSB on the commutation path holds it below a sixth edge
		set_q(0, 1, 0, 0);
		set_c(1, 3, 2);
		pin(226, 226);
		@(negedge sys_clk_i);
		absolute_angle = 12'h0e4;
		repeat (4) @(negedge sys_clk_i);
		note("pins", 1, 12'h028);
		set_c(1, 0, 2);
		$display("hysteresis test done");
		wr(`A2Q_ADDR_DIAG, 12'hfff);
		rd(`A2Q_ADDR_DIAG, 12'h003);
		note("flags", 2, 12'h000);
		wr(`A2Q_ADDR_DIAG, 12'h002);
		rd(`A2Q_ADDR_DIAG, 12'h002);
		note("flags", 2, 12'h001);
		$display("diagnosis test done");
		wr(`A2Q_ADDR_LOCK, 12'h001);
		rd(`A2Q_ADDR_LOCK, 12'h001);
		note("flags", 2, 12'h005);
		wr(`A2Q_ADDR_COMM, 12'h000);
		wr(`A2Q_ADDR_LOCK, 12'h003);
		rd(`A2Q_ADDR_COMM, 12'h042);
		rd(`A2Q_ADDR_LOCK, 12'h001);
		pin(5, 5);
		$display("lock test done");
		test_done();
	end
endmodule
